// file: core/spi_queue_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef SPI_QUEUE_CFG_SVH
`define SPI_QUEUE_CFG_SVH
`define QCTL_OFFSET 12'h040
`define QSTS_OFFSET 12'h044
`define QCTL_RESET 32'h44000000
`define QSTS_RESET 32'h05000000
`define QCTL_TX_LEVEL_HI 30
`define QCTL_TX_LEVEL_LO 28
`define QCTL_RX_LEVEL_HI 26
`define QCTL_RX_LEVEL_LO 24
`define QCTL_RX_IDLE_ON 21
`define QCTL_RX_OVF_ON 6
`define QCTL_TX_LEVEL_ON 3
`define QCTL_RX_LEVEL_ON 2
`define QCTL_TX_FLUSH 1
`define QCTL_RX_FLUSH 0
`define TX_LEVEL_RESET 3'h4
`define RX_LEVEL_RESET 3'h4
`define QSTS_TX_COUNT_HI 31
`define QSTS_TX_COUNT_LO 28
`define QSTS_TX_FULL 27
`define QSTS_TX_VACANT 26
`define QSTS_RX_FULL 25
`define QSTS_RX_VACANT 24
`define QSTS_RX_IDLE 20
`define QSTS_UNIT_DONE 16
`define QSTS_RX_COUNT_HI 15
`define QSTS_RX_COUNT_LO 12
`define QSTS_TX_LEVEL 4
`define QSTS_RX_OVF 2
`define QSTS_RX_LEVEL 0
`define IDLE_SCLK_PERIODS 64
`define IDLE_PCLK_PERIODS 576
`endif

// file: core/spi_queue_ctrl.sv
// fifo control and status registers of the serial interface, apb slave
//
// How it works
// - tx level flag is 1 while tx count is at or below tx level.
// - rx level flag is 1 while rx count exceeds rx level.
// - control bit enables the rx idle interrupt.
// - control bit enables the rx overflow interrupt.
// - control bit enables the tx level interrupt.
// - control bit enables the rx level interrupt.
// - writing 1 flushes tx queue; bit self-clears; 0 does nothing.
// - writing 1 flushes rx queue; bit self-clears; 0 does nothing.
// - status shows tx queue count as a read-only 4-bit field.
// - tx full indicator read-only, mirrored to main control reg.
// - tx vacant indicator read-only, mirrored to main control reg.
// - rx full indicator read-only, mirrored to main control reg.
// - rx vacant indicator read-only, mirrored to main control reg.
// - rx idle set after 64 sclk (master) or 576 pclk (slave) unread.
// - rx idle clears when software reads the rx queue.
// - words arriving at full rx queue dropped; overflow flag, w1c.
// - interrupt when tx level enable and tx level flag both 1.
// - interrupt when rx level enable and rx level flag both 1.
// - unit-done set per transfer, mirrored, cleared by writing 1.
`timescale 1ns/1ps
`default_nettype none
`include "spi_queue_cfg.svh"
module spi_queue_ctrl
  import spi_queue_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_push,
  input wire logic tx_pop,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic unit_done_evt,
  input wire logic slave_mode,
  input wire logic sclk_tick,
  output logic tx_flush_pulse,
  output logic rx_flush_pulse,
  output logic tx_full,
  output logic tx_vacant,
  output logic rx_full,
  output logic rx_vacant,
  output logic unit_done,
  output logic irq
);

  // software-visible control
  level_t tx_level_r, tx_level_nxt;
  level_t rx_level_r, rx_level_nxt;
  logic rx_idle_irq_on_r, rx_idle_irq_on_nxt;
  logic rx_overflow_irq_on_r, rx_overflow_irq_on_nxt;
  logic tx_level_irq_on_r, tx_level_irq_on_nxt;
  logic rx_level_irq_on_r, rx_level_irq_on_nxt;
  // queue state
  count_t tx_cnt_r, tx_cnt_nxt;
  count_t rx_cnt_r, rx_cnt_nxt;
  logic rx_ovf_r, rx_ovf_nxt;
  logic unit_done_r, unit_done_nxt;
  logic rx_idle_r, rx_idle_nxt;
  logic [9:0] idle_cnt_r, idle_cnt_nxt;
  logic tx_flush_r, tx_flush_nxt;
  logic rx_flush_r, rx_flush_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic irq_nxt;

  localparam count_t FULL_CNT = count_t'(DEPTH);
  localparam logic [9:0] IDLE_SCLK = 10'(`IDLE_SCLK_PERIODS);
  localparam logic [9:0] IDLE_PCLK = 10'(`IDLE_PCLK_PERIODS);

  logic wr_acc;
  logic hit_ctl;
  logic hit_sts;
  logic tx_lvl;
  logic rx_lvl;
  logic rx_take;
  logic rx_fifo_read;
  logic [31:0] ctl_view;
  logic [31:0] sts_view;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // zero-wait slave: answer in the first access cycle
  assign wr_acc = psel && penable && pwrite && pready;
  assign hit_ctl = addr_is(paddr, `QCTL_OFFSET);
  assign hit_sts = addr_is(paddr, `QSTS_OFFSET);
  assign tx_lvl = (tx_cnt_r <= {1'b0, tx_level_r});
  assign rx_lvl = (rx_cnt_r > {1'b0, rx_level_r});
  assign rx_take = rx_push && (rx_cnt_r != FULL_CNT);
  assign rx_fifo_read = rx_pop && (rx_cnt_r != 4'h0);

  always_comb
  begin
    ctl_view = 32'h0;
    ctl_view[`QCTL_TX_LEVEL_HI:`QCTL_TX_LEVEL_LO] = tx_level_r;
    ctl_view[`QCTL_RX_LEVEL_HI:`QCTL_RX_LEVEL_LO] = rx_level_r;
    ctl_view[`QCTL_RX_IDLE_ON] = rx_idle_irq_on_r;
    ctl_view[`QCTL_RX_OVF_ON] = rx_overflow_irq_on_r;
    ctl_view[`QCTL_TX_LEVEL_ON] = tx_level_irq_on_r;
    ctl_view[`QCTL_RX_LEVEL_ON] = rx_level_irq_on_r;
    ctl_view[`QCTL_TX_FLUSH] = tx_flush_r;
    ctl_view[`QCTL_RX_FLUSH] = rx_flush_r;
    sts_view = 32'h0;
    sts_view[`QSTS_TX_COUNT_HI:`QSTS_TX_COUNT_LO] = tx_cnt_r;
    sts_view[`QSTS_TX_FULL] = (tx_cnt_r == FULL_CNT);
    sts_view[`QSTS_TX_VACANT] = (tx_cnt_r == 4'h0);
    sts_view[`QSTS_RX_FULL] = (rx_cnt_r == FULL_CNT);
    sts_view[`QSTS_RX_VACANT] = (rx_cnt_r == 4'h0);
    sts_view[`QSTS_RX_IDLE] = rx_idle_r;
    sts_view[`QSTS_UNIT_DONE] = unit_done_r;
    sts_view[`QSTS_RX_COUNT_HI:`QSTS_RX_COUNT_LO] = rx_cnt_r;
    sts_view[`QSTS_TX_LEVEL] = tx_lvl;
    sts_view[`QSTS_RX_OVF] = rx_ovf_r;
    sts_view[`QSTS_RX_LEVEL] = rx_lvl;
  end

  // bus answer and control register
  always_comb
  begin
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !hit_ctl && !hit_sts;
    prdata_nxt = prdata;
    if (psel && !penable && !pwrite)
    begin
      prdata_nxt = hit_ctl ? ctl_view : (hit_sts ? sts_view : 32'h0);
    end
    tx_level_nxt = tx_level_r;
    rx_level_nxt = rx_level_r;
    rx_idle_irq_on_nxt = rx_idle_irq_on_r;
    rx_overflow_irq_on_nxt = rx_overflow_irq_on_r;
    tx_level_irq_on_nxt = tx_level_irq_on_r;
    rx_level_irq_on_nxt = rx_level_irq_on_r;
    // flush bits live one cycle, then drop by themselves
    tx_flush_nxt = 1'b0;
    rx_flush_nxt = 1'b0;
    if (wr_acc && hit_ctl)
    begin
      tx_level_nxt = pwdata[`QCTL_TX_LEVEL_HI:`QCTL_TX_LEVEL_LO];
      rx_level_nxt = pwdata[`QCTL_RX_LEVEL_HI:`QCTL_RX_LEVEL_LO];
      rx_idle_irq_on_nxt = pwdata[`QCTL_RX_IDLE_ON];
      rx_overflow_irq_on_nxt = pwdata[`QCTL_RX_OVF_ON];
      tx_level_irq_on_nxt = pwdata[`QCTL_TX_LEVEL_ON];
      rx_level_irq_on_nxt = pwdata[`QCTL_RX_LEVEL_ON];
      tx_flush_nxt = pwdata[`QCTL_TX_FLUSH];
      rx_flush_nxt = pwdata[`QCTL_RX_FLUSH];
    end
  end

  // queue counts, sticky flags, idle timer
  always_comb
  begin
    tx_cnt_nxt = tx_cnt_r;
    if (tx_push && !tx_pop && tx_cnt_r != FULL_CNT)
      tx_cnt_nxt = tx_cnt_r + 4'h1;
    else if (tx_pop && !tx_push && tx_cnt_r != 4'h0)
      tx_cnt_nxt = tx_cnt_r - 4'h1;
    if (tx_flush_r)
      tx_cnt_nxt = 4'h0;
    rx_cnt_nxt = rx_cnt_r;
    if (rx_take && !rx_fifo_read)
      rx_cnt_nxt = rx_cnt_r + 4'h1;
    else if (rx_fifo_read && !rx_push)
      rx_cnt_nxt = rx_cnt_r - 4'h1;
    if (rx_flush_r)
      rx_cnt_nxt = 4'h0;
    // set beats write-one-clear in the same cycle
    rx_ovf_nxt = rx_ovf_r;
    if (wr_acc && hit_sts && pwdata[`QSTS_RX_OVF])
      rx_ovf_nxt = 1'b0;
    if (rx_push && rx_cnt_r == FULL_CNT && !rx_fifo_read)
      rx_ovf_nxt = 1'b1;
    unit_done_nxt = unit_done_r;
    if (wr_acc && hit_sts && pwdata[`QSTS_UNIT_DONE])
      unit_done_nxt = 1'b0;
    if (unit_done_evt)
      unit_done_nxt = 1'b1;
    // timer restarts on every read or when the queue is empty
    idle_cnt_nxt = idle_cnt_r;
    rx_idle_nxt = rx_idle_r;
    if (rx_fifo_read || rx_cnt_r == 4'h0)
    begin
      idle_cnt_nxt = 10'h0;
      if (rx_fifo_read)
        rx_idle_nxt = 1'b0;
    end
    else if (slave_mode || sclk_tick)
    begin
      if (idle_cnt_r != 10'h3ff)
        idle_cnt_nxt = idle_cnt_r + 10'h1;
      if (idle_cnt_r + 10'h1 >= (slave_mode ? IDLE_PCLK : IDLE_SCLK))
        rx_idle_nxt = 1'b1;
    end
    irq_nxt = (tx_level_irq_on_r && tx_lvl)
      || (rx_level_irq_on_r && rx_lvl)
      || (rx_idle_irq_on_r && rx_idle_r)
      || (rx_overflow_irq_on_r && rx_ovf_r);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_level_r <= `TX_LEVEL_RESET;
      rx_level_r <= `RX_LEVEL_RESET;
      rx_idle_irq_on_r <= 1'b0;
      rx_overflow_irq_on_r <= 1'b0;
      tx_level_irq_on_r <= 1'b0;
      rx_level_irq_on_r <= 1'b0;
      tx_flush_r <= 1'b0;
      rx_flush_r <= 1'b0;
      tx_cnt_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_ovf_r <= 1'b0;
      unit_done_r <= 1'b0;
      rx_idle_r <= 1'b0;
      idle_cnt_r <= 10'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      tx_flush_pulse <= 1'b0;
      rx_flush_pulse <= 1'b0;
      tx_full <= 1'b0;
      tx_vacant <= 1'b1;
      rx_full <= 1'b0;
      rx_vacant <= 1'b1;
      unit_done <= 1'b0;
    end
    else
    begin
      tx_level_r <= tx_level_nxt;
      rx_level_r <= rx_level_nxt;
      rx_idle_irq_on_r <= rx_idle_irq_on_nxt;
      rx_overflow_irq_on_r <= rx_overflow_irq_on_nxt;
      tx_level_irq_on_r <= tx_level_irq_on_nxt;
      rx_level_irq_on_r <= rx_level_irq_on_nxt;
      tx_flush_r <= tx_flush_nxt;
      rx_flush_r <= rx_flush_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_ovf_r <= rx_ovf_nxt;
      unit_done_r <= unit_done_nxt;
      rx_idle_r <= rx_idle_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
      tx_flush_pulse <= tx_flush_nxt;
      rx_flush_pulse <= rx_flush_nxt;
      // mirrors for the main control register
      tx_full <= (tx_cnt_nxt == FULL_CNT);
      tx_vacant <= (tx_cnt_nxt == 4'h0);
      rx_full <= (rx_cnt_nxt == FULL_CNT);
      rx_vacant <= (rx_cnt_nxt == 4'h0);
      unit_done <= unit_done_nxt;
    end
  end

  a_tx_flush_empties: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    tx_flush_r |=> tx_cnt_r == 4'h0 && !tx_flush_r && tx_vacant)
    else $error("tx flush did not empty queue");
  a_rx_flush_empties: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rx_flush_r |=> rx_cnt_r == 4'h0 && !rx_flush_r && rx_vacant)
    else $error("rx flush did not empty queue");
  a_rx_ovf_sets: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rx_push && rx_cnt_r == FULL_CNT && !rx_fifo_read && !rx_flush_r
    |=> rx_ovf_r && rx_cnt_r == FULL_CNT)
    else $error("overflow not flagged");
  a_rx_idle_clears: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rx_fifo_read |=> !rx_idle_r)
    else $error("idle flag kept after read");
  a_rx_idle_slave: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    slave_mode && idle_cnt_r == (IDLE_PCLK - 10'h1) && rx_cnt_r != 4'h0
    && !rx_fifo_read |=> rx_idle_r)
    else $error("slave idle time-out missed");
  a_irq_tx_level: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    tx_level_irq_on_r && tx_lvl |=> irq)
    else $error("tx level irq missing");
  a_irq_rx_level: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rx_level_irq_on_r && rx_lvl |=> irq)
    else $error("rx level irq missing");
  a_unit_done_sets: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    unit_done_evt |=> unit_done_r && unit_done)
    else $error("unit done not set");
  a_status_mirror: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    tx_full == (tx_cnt_r == FULL_CNT) && rx_vacant == (rx_cnt_r == 4'h0))
    else $error("mirror out of step");
  c_overflow: cover property (@(posedge clk_sys) rx_ovf_r && irq);
  c_idle: cover property (@(posedge clk_sys) $rose(rx_idle_r));
  c_flush: cover property (@(posedge clk_sys) tx_flush_r && tx_cnt_r != 4'h0);

endmodule
`default_nettype wire

// file: core/spi_queue_pkg.sv
// types shared by the queue control and status block
`default_nettype none
package spi_queue_pkg;
  typedef logic [3:0] count_t;
  typedef logic [2:0] level_t;
endpackage
`default_nettype wire

// file: tb/spi_fifo_control_status_test.sv
// self-checking bench for the queue control and status block
`timescale 1ns/1ps
`default_nettype none
`include "spi_queue_cfg.svh"
module spi_fifo_control_status_test import spi_queue_pkg::*;;
  logic clk_sys, arst_n, psel, penable, pwrite, slave_mode, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, tx_flush_pulse, rx_flush_pulse, tx_full, tx_vacant;
  logic rx_full, rx_vacant, unit_done, irq;
  // strobes: tx push, tx pop, rx push, rx pop, unit done, sclk tick
  logic [5:0] ev;
  int errors, checks;
  // tx level flag is live: an empty tx queue sits at or below its level
  localparam logic [31:0] STS_IDLE = `QSTS_RESET | (32'h1 << `QSTS_TX_LEVEL);

  spi_queue_ctrl #(.DEPTH(8)) spi_queue_ctrl_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_push(ev[0]), .tx_pop(ev[1]), .rx_push(ev[2]),
    .rx_pop(ev[3]), .unit_done_evt(ev[4]), .slave_mode(slave_mode),
    .sclk_tick(ev[5]), .tx_flush_pulse(tx_flush_pulse),
    .rx_flush_pulse(rx_flush_pulse), .tx_full(tx_full),
    .tx_vacant(tx_vacant), .rx_full(rx_full), .rx_vacant(rx_vacant),
    .unit_done(unit_done), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask

  // holds the request until pready is seen high, gives up after 20 more cycles
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1)
      errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      ev[b] <= 1'b1;
      @(posedge clk_sys);
      ev[b] <= 1'b0;
    end
  endtask

  task automatic t_reset;
    rdchk(`QCTL_OFFSET, `QCTL_RESET);
    rdchk(`QSTS_OFFSET, STS_IDLE);
    apb(1'b1, `QSTS_OFFSET, 32'hffffffff);
    rdchk(`QSTS_OFFSET, STS_IDLE);
    apb(1'b0, 12'h048, 32'h0);
    chk1(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic t_tx;
    apb(1'b1, `QCTL_OFFSET, 32'h24000008);
    rdchk(`QSTS_OFFSET, 32'h05000010);
    chk1(irq, 1'b1);
    pulse(0, 3);
    rdchk(`QSTS_OFFSET, 32'h31000000);
    chk1(irq, 1'b0);
    pulse(1, 1);
    rdchk(`QSTS_OFFSET, 32'h21000010);
    chk1(irq, 1'b1);
    pulse(0, 6);
    rdchk(`QSTS_OFFSET, 32'h89000000);
    chk1(tx_full, 1'b1);
    apb(1'b1, `QCTL_OFFSET, 32'h24000002);
    @(negedge clk_sys) chk1(tx_flush_pulse, 1'b1);
    chk1(rx_flush_pulse, 1'b0);
    rdchk(`QSTS_OFFSET, 32'h05000010);
    chk1(tx_flush_pulse, 1'b0);
    rdchk(`QCTL_OFFSET, 32'h24000000);
    chk1(irq, 1'b0);
    chk1(tx_vacant, 1'b1);
  endtask

  task automatic t_rx;
    apb(1'b1, `QCTL_OFFSET, 32'h44000044);
    pulse(2, 4);
    rdchk(`QSTS_OFFSET, 32'h04004010);
    chk1(irq, 1'b0);
    pulse(2, 1);
    rdchk(`QSTS_OFFSET, 32'h04005011);
    chk1(irq, 1'b1);
    pulse(2, 4);
    rdchk(`QSTS_OFFSET, 32'h06008015);
    chk1(rx_full, 1'b1);
    apb(1'b1, `QCTL_OFFSET, 32'h44000040);
    rdchk(`QSTS_OFFSET, 32'h06008015);
    chk1(irq, 1'b1);
    apb(1'b1, `QSTS_OFFSET, 32'h00000004);
    rdchk(`QSTS_OFFSET, 32'h06008011);
    chk1(irq, 1'b0);
    apb(1'b1, `QCTL_OFFSET, 32'h44000001);
    @(negedge clk_sys) chk1(rx_flush_pulse, 1'b1);
    chk1(tx_flush_pulse, 1'b0);
    rdchk(`QSTS_OFFSET, 32'h05000010);
    chk1(rx_flush_pulse, 1'b0);
    chk1(rx_vacant, 1'b1);
  endtask

  // margins around 576 and 64 leave room for the flag's own latency
  task automatic t_idle;
    apb(1'b1, `QCTL_OFFSET, 32'h44200000);
    slave_mode <= 1'b1;
    pulse(2, 1);
    repeat (540) @(posedge clk_sys);
    rdchk(`QSTS_OFFSET, 32'h04001010);
    repeat (60) @(posedge clk_sys);
    rdchk(`QSTS_OFFSET, 32'h04101010);
    chk1(irq, 1'b1);
    pulse(3, 1);
    rdchk(`QSTS_OFFSET, 32'h05000010);
    chk1(irq, 1'b0);
    slave_mode <= 1'b0;
    pulse(2, 1);
    pulse(5, 60);
    rdchk(`QSTS_OFFSET, 32'h04001010);
    pulse(5, 10);
    rdchk(`QSTS_OFFSET, 32'h04101010);
    apb(1'b1, `QCTL_OFFSET, 32'h44000000);
    rdchk(`QSTS_OFFSET, 32'h04101010);
    chk1(irq, 1'b0);
    pulse(3, 1);
  endtask

  task automatic t_done;
    pulse(4, 1);
    rdchk(`QSTS_OFFSET, 32'h05010010);
    chk1(unit_done, 1'b1);
    apb(1'b1, `QSTS_OFFSET, 32'h00010000);
    rdchk(`QSTS_OFFSET, 32'h05000010);
    chk1(unit_done, 1'b0);
  endtask

  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_sim;
  end

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ev = 6'h0;
    slave_mode = 1'b0;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_idle;
    t_done;
    end_sim;
  end
endmodule
`default_nettype wire
